// ===== hdl/urswp_pkg.sv
// Purpose: shared constants and types for the upstream role swap block
// Assumes: one 125 MHz clock, asynchronous active-low reset
// Notes: the register map lives on a plain strobe port

package urswp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] URSWP_ADDR_CTRL = 4'h0;
  localparam logic [3:0] URSWP_ADDR_STAT = 4'h1;
  localparam logic [3:0] URSWP_ADDR_CMD = 4'h2;
  localparam int URSWP_CTRL_ACT_BIT = 0;
  localparam int URSWP_CTRL_MODE_BIT = 1;
  localparam int URSWP_CTRL_P1DIS_BIT = 2;
  localparam int URSWP_CTRL_P1OFF_BIT = 3;
  localparam int URSWP_CMD_ATTACH_BIT = 0;
  localparam logic [7:0] URSWP_CTRL_RESET = 8'h00;
  localparam logic [7:0] URSWP_RDATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing and strap
  // ----------------------------------------------------------------
  localparam int URSWP_SELF_RESET_NS = 64;
  localparam int URSWP_CLK_NS = 8;
  localparam int URSWP_SELF_RESET_CYC =
    (URSWP_SELF_RESET_NS + URSWP_CLK_NS - 1) / URSWP_CLK_NS;
  localparam logic [3:0] URSWP_CNT_RESET = 4'h0;
  localparam logic [3:0] URSWP_SYNC_WAIT = 4'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    URSWP_CFG = 2'b00,
    URSWP_RUN = 2'b01,
    URSWP_SRST = 2'b11
  } urswp_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } urswp_bus_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
  } urswp_pad_t;

  typedef struct packed {
    urswp_state_t st;
    logic [7:0] ctrl;
    logic swap;
    logic mode;
    logic pin_s1;
    logic pin_s2;
    logic pin_last;
    logic pin_seen;
    logic [3:0] cnt;
    logic [7:0] rdata;
  } urswp_state_vec_t;

endpackage

// ===== hdl/urswp_top.sv
// Purpose: port role swap and pin function multiplexing
// Assumes: hub core supplies port enable and runtime handshake
// Notes: pin_ctrl_variant selects the pin-controlled build
// How it works
// - Only physical port 1 swaps with upstream
// - Upstream physical port reported for logical remap
// - Activate bit and mode-enable bit control swap
// - Swap bits writable only in configuration stage
// - Mode, no swap: combined pin, suspend low
// - Swapped: pin12 high, pin13 detect, pin28 combined
// - Combined enabled: input, pull-up, watch overcurrent
// - Combined disabled: output driven low
// - Swap pin selects roles on pin variant
// - Swap pin change resets the device
// - SMBus mode waits for attach after toggle
// - Port 0 may act downstream while swapped
// - Port 1 disable bit silences whichever of ports 0 and 1 is downstream
// - Power detect drives upstream pull-up
`timescale 1ns/100ps
`default_nettype none

module urswp_top
  import urswp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin_ctrl_variant,
  input wire logic smbus_cfg_mode,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic swap_select_pin,
  input wire logic host_port1_enable,
  input wire logic core_suspend_indicator,
  input wire logic core_port1_power_enable,
  input wire logic pin12_i,
  output logic pin12_o,
  output logic pin12_oe,
  output logic pin12_pu,
  input wire logic pin13_i,
  output logic pin28_o,
  output logic pin28_oe,
  output logic pin28_pu,
  input wire logic pin28_i,
  input wire logic pin27_i,
  output logic port1_overcurrent_n,
  output logic upstream_power_detect,
  output logic upstream_pullup,
  output logic upstream_is_port1,
  output logic port0_functional,
  output logic port1_functional,
  output logic hub_runtime,
  output logic self_reset
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  urswp_state_vec_t s_q;
  urswp_state_vec_t s_d;
  urswp_bus_t bus;
  urswp_pad_t comb_pad;
  logic comb_en;
  logic comb_ocn;
  logic p1_disabled;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign p1_disabled = s_q.ctrl[URSWP_CTRL_P1DIS_BIT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pin_s1 = swap_select_pin;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.rdata = URSWP_RDATA_RESET;
    if (bus.rd) begin
      unique case (bus.addr)
        URSWP_ADDR_CTRL: s_d.rdata = s_q.ctrl;
        URSWP_ADDR_STAT: s_d.rdata = {3'h0, s_q.st == URSWP_RUN,
          s_q.pin_last, s_q.mode, s_q.swap, upstream_power_detect};
        default: s_d.rdata = URSWP_RDATA_RESET;
      endcase
    end
    unique case (s_q.st)
      URSWP_CFG: begin
        if (bus.wr && bus.addr == URSWP_ADDR_CTRL) begin
          s_d.ctrl = bus.wdata;
        end
        if (!s_q.pin_seen) begin
          // Wait until the synchroniser holds the real pin level
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == URSWP_SYNC_WAIT) begin
            s_d.pin_seen = 1'b1;
            s_d.pin_last = s_q.pin_s2;
            s_d.cnt = URSWP_CNT_RESET;
          end
        end else if (pin_ctrl_variant && s_q.pin_s2 != s_q.pin_last) begin
          s_d.st = URSWP_SRST;
        end else if (!smbus_cfg_mode || (bus.wr &&
            bus.addr == URSWP_ADDR_CMD &&
            bus.wdata[URSWP_CMD_ATTACH_BIT])) begin
          s_d.st = URSWP_RUN;
          if (pin_ctrl_variant) begin
            s_d.swap = s_q.pin_last;
            s_d.mode = 1'b1;
          end else begin
            // activate without mode enable leaves roles unswapped
            s_d.swap = s_q.ctrl[URSWP_CTRL_ACT_BIT] &
              s_q.ctrl[URSWP_CTRL_MODE_BIT];
            s_d.mode = s_q.ctrl[URSWP_CTRL_MODE_BIT];
          end
        end
      end
      URSWP_RUN: begin
        if (pin_ctrl_variant && s_q.pin_s2 != s_q.pin_last) begin
          s_d.st = URSWP_SRST;
        end
      end
      URSWP_SRST: begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt == 4'(URSWP_SELF_RESET_CYC - 1)) begin
          s_d = '0;
          s_d.ctrl = URSWP_CTRL_RESET;
          s_d.cnt = URSWP_CNT_RESET;
          s_d.st = URSWP_CFG;
          s_d.pin_s1 = swap_select_pin;
          s_d.pin_s2 = s_q.pin_s1;
        end
      end
      default: s_d.st = URSWP_CFG;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Combined power and overcurrent pad
  // ----------------------------------------------------------------
  assign comb_en = host_port1_enable & ~s_q.ctrl[URSWP_CTRL_P1OFF_BIT] &
    core_port1_power_enable;
  always_comb begin
    if (comb_en) begin
      comb_pad = '{o: 1'b0, oe: 1'b0, pu: 1'b1};
    end else begin
      comb_pad = '{o: 1'b0, oe: 1'b1, pu: 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Pin function multiplexing
  // ----------------------------------------------------------------
  always_comb begin
    pin12_o = core_port1_power_enable;
    pin12_oe = 1'b1;
    pin12_pu = 1'b0;
    pin28_o = core_suspend_indicator;
    pin28_oe = 1'b1;
    pin28_pu = 1'b0;
    comb_ocn = 1'b1;
    port1_overcurrent_n = pin13_i;
    upstream_power_detect = pin27_i;
    if (s_q.mode && !s_q.swap) begin
      {pin12_o, pin12_oe, pin12_pu} = comb_pad;
      comb_ocn = pin12_i | ~comb_en;
      port1_overcurrent_n = comb_ocn;
      pin28_o = 1'b0;
    end else if (s_q.mode && s_q.swap) begin
      pin12_o = 1'b1;
      upstream_power_detect = pin13_i;
      {pin28_o, pin28_oe, pin28_pu} = comb_pad;
      comb_ocn = pin28_i | ~comb_en;
      port1_overcurrent_n = comb_ocn;
    end
    if (s_q.st != URSWP_RUN) begin
      upstream_power_detect = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Role outputs
  // ----------------------------------------------------------------
  assign upstream_is_port1 = s_q.swap;
  assign upstream_pullup = upstream_power_detect;
  assign hub_runtime = s_q.st == URSWP_RUN;
  assign port0_functional = hub_runtime &
    (~s_q.swap | ~p1_disabled);
  assign port1_functional = hub_runtime &
    (s_q.swap | ~p1_disabled);
  assign self_reset = s_q.st == URSWP_SRST;
  assign reg_rdata = s_q.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_swap_frozen;
    @(posedge clk) disable iff (!rst_b)
    (hub_runtime && $past(hub_runtime)) |-> $stable(s_q.swap);
  endproperty
  a_swap_frozen: assert property (p_swap_frozen)
    else $error("swap changed during runtime");

  property p_no_bad_swap;
    @(posedge clk) disable iff (!rst_b)
    s_q.swap |-> s_q.mode;
  endproperty
  a_no_bad_swap: assert property (p_no_bad_swap)
    else $error("swap without mode enable");

  property p_cfg_write;
    @(posedge clk) disable iff (!rst_b)
    (hub_runtime && reg_wr && reg_addr == URSWP_ADDR_CTRL) |=>
      $stable(s_q.ctrl);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("control written in runtime");

  property p_toggle_reset;
    @(posedge clk) disable iff (!rst_b)
    (pin_ctrl_variant && hub_runtime && s_q.pin_s2 != s_q.pin_last) |=>
      self_reset;
  endproperty
  a_toggle_reset: assert property (p_toggle_reset)
    else $error("pin toggle gave no reset");

  property p_swapped_pins;
    @(posedge clk) disable iff (!rst_b)
    (s_q.mode && s_q.swap) |-> (pin12_o && pin12_oe &&
      upstream_power_detect == (pin13_i && hub_runtime));
  endproperty
  a_swapped_pins: assert property (p_swapped_pins)
    else $error("swapped pin map wrong");

  property p_unswapped_pins;
    @(posedge clk) disable iff (!rst_b)
    (s_q.mode && !s_q.swap) |-> (!pin28_o && pin28_oe);
  endproperty
  a_unswapped_pins: assert property (p_unswapped_pins)
    else $error("suspend pin not low");

  property p_comb_off;
    @(posedge clk) disable iff (!rst_b)
    (s_q.mode && !s_q.swap && !comb_en) |-> (pin12_oe && !pin12_o);
  endproperty
  a_comb_off: assert property (p_comb_off)
    else $error("disabled combined pin not low");

  property p_comb_on;
    @(posedge clk) disable iff (!rst_b)
    (s_q.mode && !s_q.swap && comb_en) |->
      (!pin12_oe && pin12_pu && port1_overcurrent_n == pin12_i);
  endproperty
  a_comb_on: assert property (p_comb_on)
    else $error("enabled combined pin not input");

  property p_attach;
    @(posedge clk) disable iff (!rst_b)
    (smbus_cfg_mode && s_q.st == URSWP_CFG && s_q.pin_seen &&
      !(pin_ctrl_variant && s_q.pin_s2 != s_q.pin_last) &&
      !(reg_wr && reg_addr == URSWP_ADDR_CMD)) |=> !hub_runtime;
  endproperty
  a_attach: assert property (p_attach)
    else $error("runtime without attach");

  property p_pullup;
    @(posedge clk) disable iff (!rst_b)
    upstream_pullup == (hub_runtime &&
      ((s_q.mode && s_q.swap) ? pin13_i : pin27_i));
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up differs from detect");

endmodule

`default_nettype wire

// ===== testbench/urswp_board.sv
// Purpose: board model of power switch, current monitor and host power
// Assumes: pads resolve without delay
// Notes: a pad nobody drives or pulls shows the inverse of its output value
`timescale 1ns/100ps
`default_nettype none
module urswp_board
(
  input wire logic p12_o,
  input wire logic p12_oe,
  input wire logic p12_pu,
  input wire logic p28_o,
  input wire logic p28_oe,
  input wire logic p28_pu,
  input wire logic up_p1,
  input wire logic oc_fault,
  input wire logic vbus,
  output logic pin12_i,
  output logic pin28_i,
  output logic pin13_i,
  output logic pin27_i
);
  // Monitor pulls the combined pad low on a fault
  assign pin12_i = p12_oe ? p12_o :
    (oc_fault ? 1'h0 : (p12_pu | ~p12_o));
  assign pin28_i = p28_oe ? p28_o :
    (oc_fault ? 1'h0 : (p28_pu | ~p28_o));
  // Ignored pads carry a conflicting level
  assign pin13_i = up_p1 ? vbus : oc_fault;
  assign pin27_i = up_p1 ? ~vbus : vbus;
endmodule
`default_nettype wire

// ===== testbench/urswp_top_tb_top.sv
// Purpose: self-checking bench for the role swap block
// Assumes: 125 MHz clock, reset held 4 cycles
// Notes: register flows use the attach command
`timescale 1ns/100ps
`default_nettype none
module urswp_top_tb_top;
  import urswp_pkg::*;
  logic clk = 1'h0, rst_b = 1'h0, pin_ctrl_variant = 1'h0;
  logic smbus_cfg_mode = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic swap_select_pin = 1'h0, host_port1_enable = 1'h1;
  logic core_suspend_indicator = 1'h1, core_port1_power_enable = 1'h1;
  logic oc_fault = 1'h0, vbus = 1'h1;
  wire logic [7:0] reg_rdata;
  wire logic pin12_i, pin12_o, pin12_oe, pin12_pu, pin13_i, pin27_i;
  wire logic pin28_i, pin28_o, pin28_oe, pin28_pu, port1_overcurrent_n;
  wire logic upstream_power_detect, upstream_pullup, upstream_is_port1;
  wire logic port0_functional, port1_functional, hub_runtime, self_reset;
  wire logic [7:0] pads, flags;
  int err_total = 0, checks_done = 0;
  assign pads = {2'h0, pin12_o, pin12_oe, pin12_pu, pin28_o, pin28_oe,
    pin28_pu};
  assign flags = {port1_overcurrent_n, upstream_power_detect,
    upstream_pullup, upstream_is_port1, port0_functional, port1_functional,
    hub_runtime, self_reset};
  always #4 clk = ~clk;
  urswp_top urswp_top_i (.clk, .rst_b, .pin_ctrl_variant, .smbus_cfg_mode,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .swap_select_pin,
    .host_port1_enable, .core_suspend_indicator, .core_port1_power_enable,
    .pin12_i, .pin12_o, .pin12_oe, .pin12_pu, .pin13_i, .pin28_o,
    .pin28_oe, .pin28_pu, .pin28_i, .pin27_i, .port1_overcurrent_n,
    .upstream_power_detect, .upstream_pullup, .upstream_is_port1,
    .port0_functional, .port1_functional, .hub_runtime, .self_reset);
  urswp_board urswp_board_i (.p12_o(pin12_o), .p12_oe(pin12_oe),
    .p12_pu(pin12_pu), .p28_o(pin28_o), .p28_oe(pin28_oe),
    .p28_pu(pin28_pu), .up_p1(upstream_is_port1), .oc_fault, .vbus,
    .pin12_i, .pin28_i, .pin13_i, .pin27_i);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk8(reg_rdata, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic v, input logic s);
    @(posedge clk);
    rst_b <= 1'h0;
    pin_ctrl_variant <= v;
    smbus_cfg_mode <= s;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
  endtask
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    #1;
    while (flags[b] !== 1'h1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk8({7'h0, flags[b]}, 8'h01);
  endtask
  task automatic attach();
    wr(URSWP_ADDR_CMD, 8'h01);
    wait_bit(1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_mode();
    do_reset(1'h0, 1'h1);
    settle();
    chk8(pads, 8'h36);
    wr(URSWP_ADDR_CTRL, 8'h0A);
    attach();
    chk8(pads & 8'h38, 8'h10);
    do_reset(1'h0, 1'h1);
    wr(URSWP_ADDR_CTRL, 8'h02);
    attach();
    chk8(pads & 8'h1F, 8'h0A);
    chk8(flags & 8'h80, 8'h80);
    @(posedge clk) oc_fault <= 1'h1;
    settle();
    chk8(flags & 8'h80, 8'h00);
    @(posedge clk) host_port1_enable <= 1'h0;
    settle();
    chk8(pads & 8'h38, 8'h10);
    @(posedge clk) host_port1_enable <= 1'h1;
    @(posedge clk) oc_fault <= 1'h0;
    wr(URSWP_ADDR_CTRL, 8'h03);
    rd(URSWP_ADDR_CTRL, 8'h02);
    chk8(flags & 8'h10, 8'h00);
  endtask
  task automatic s_swap();
    do_reset(1'h0, 1'h1);
    wr(URSWP_ADDR_CTRL, 8'h07);
    attach();
    chk8(pads & 8'h3B, 8'h31);
    chk8(flags, 8'hF6);
    @(posedge clk) vbus <= 1'h0;
    @(posedge clk) oc_fault <= 1'h1;
    settle();
    chk8(flags, 8'h16);
    rd(URSWP_ADDR_STAT, 8'h16);
    rd(4'hF, 8'h00);
    @(posedge clk) swap_select_pin <= 1'h1;
    repeat (12) @(posedge clk);
    #1;
    chk8(flags, 8'h16);
    @(posedge clk) oc_fault <= 1'h0;
    @(posedge clk) vbus <= 1'h1;
    @(posedge clk) swap_select_pin <= 1'h0;
  endtask
  task automatic s_unsup();
    do_reset(1'h0, 1'h1);
    wr(URSWP_ADDR_CTRL, 8'h05);
    attach();
    chk8(flags & 8'h10, 8'h00);
    chk8(pads & 8'h07, 8'h06);
    chk8(flags & 8'h0C, 8'h08);
  endtask
  task automatic s_pin();
    @(posedge clk) swap_select_pin <= 1'h1;
    do_reset(1'h1, 1'h0);
    wait_bit(1);
    chk8(flags & 8'h11, 8'h10);
    chk8(pads & 8'h38, 8'h30);
    @(posedge clk) swap_select_pin <= 1'h0;
    wait_bit(0);
    wait_bit(1);
    chk8(flags & 8'h10, 8'h00);
    chk8(pads & 8'h1F, 8'h0A);
    @(posedge clk) smbus_cfg_mode <= 1'h1;
    @(posedge clk) swap_select_pin <= 1'h1;
    wait_bit(0);
    repeat (20) @(posedge clk);
    #1;
    chk8(flags & 8'h02, 8'h00);
    attach();
    chk8(flags & 8'h10, 8'h10);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    s_mode();
    s_swap();
    s_unsup();
    s_pin();
    tally_and_finish();
  end
  initial begin
    #40000;
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
